//--- design/mbex_core.sv
/*
  Request checker and exception reply former for a Modbus slave or gateway
  endpoint, with legacy reference decoding and wide-value word pairing.
  Assumes framing, checksum and unit matching are done upstream and that
  all inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module mbex_core
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Parsed request from the framing logic
  input wire logic req_valid,
  input var mbex_pkg::mbex_req_t req,
  input wire logic frame_ok,
  input wire logic unit_match,
  // Configuration of the local register maps, indexed by register type
  input var mbex_pkg::mbex_map_t [3:0] map_cfg,
  input wire logic gateway_mode,
  // Device and downstream conditions
  input wire logic dev_fault,
  input wire logic dev_busy,
  input wire logic gw_no_path,
  input wire logic gw_no_answer,
  input wire logic gw_timeout,
  // Reply header to the transmit side
  output logic rsp_valid,
  output mbex_pkg::mbex_rsp_t rsp,
  output mbex_pkg::mbex_type_t rsp_type,
  // Legacy reference decoder
  input wire logic [19:0] ref_num,
  input wire logic ref_six,
  input wire logic [3:0] ref_bit,
  output mbex_pkg::mbex_ref_t ref_out,
  // Bit pick from a 16-bit register word
  input wire logic [15:0] bit_word,
  output logic bit_out,
  // Wide-value pairing
  input wire logic word_swap,
  input wire logic [2:0] wide_regs,
  input wire logic [63:0] wide_in,
  output logic [63:0] wide_regs_out,
  input wire logic [63:0] regs_in,
  output logic [63:0] wide_out
);

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------

  // The register type follows the function code alone, since all four
  // types use the same address values.
  function automatic mbex_pkg::mbex_type_t fc_type(input logic [7:0] fc);
    mbex_pkg::mbex_type_t t;
    t = mbex_pkg::MBEX_HOLD;
    unique case (fc)
      mbex_pkg::FC_RD_COIL, mbex_pkg::FC_WR_COIL,
      mbex_pkg::FC_WM_COIL: t = mbex_pkg::MBEX_COIL;
      mbex_pkg::FC_RD_DISC: t = mbex_pkg::MBEX_DISC;
      mbex_pkg::FC_RD_INPT: t = mbex_pkg::MBEX_INPT;
      default: t = mbex_pkg::MBEX_HOLD;
    endcase
    return t;
  endfunction

  function automatic logic fc_known(input logic [7:0] fc);
    return fc == mbex_pkg::FC_RD_COIL || fc == mbex_pkg::FC_RD_DISC ||
           fc == mbex_pkg::FC_RD_HOLD || fc == mbex_pkg::FC_RD_INPT ||
           fc == mbex_pkg::FC_WR_COIL || fc == mbex_pkg::FC_WR_HOLD ||
           fc == mbex_pkg::FC_WM_COIL || fc == mbex_pkg::FC_WM_HOLD;
  endfunction

  function automatic logic fc_write(input logic [7:0] fc);
    return fc == mbex_pkg::FC_WR_COIL || fc == mbex_pkg::FC_WR_HOLD ||
           fc == mbex_pkg::FC_WM_COIL || fc == mbex_pkg::FC_WM_HOLD;
  endfunction

  function automatic logic fc_single(input logic [7:0] fc);
    return fc == mbex_pkg::FC_WR_COIL || fc == mbex_pkg::FC_WR_HOLD;
  endfunction

  // ----------------------------------------------------------------
  // Request checking
  // ----------------------------------------------------------------
  mbex_pkg::mbex_type_t req_type;
  mbex_pkg::mbex_map_t map_sel;
  logic [16:0] span_end;
  logic func_bad;
  logic addr_bad;
  logic value_bad;
  logic [7:0] exc_code;

  // Checks run in priority order: gateway path, then device state, then
  // function, address and data value, as a slave would meet them.
  always_comb
  begin
    req_type = fc_type(req.func);
    map_sel = map_cfg[req_type];
    span_end = {1'b0, req.addr} +
               (fc_single(req.func) ? 17'h00001 : {1'b0, req.qty});
    func_bad = !fc_known(req.func) ||
               (fc_write(req.func) ? !map_sel.wr_ok
                                   : !map_sel.rd_ok);
    // Any register past the map end fails the whole span; the address
    // field is 16 bits so each space stops at 65535.
    addr_bad = span_end > map_sel.size ||
               span_end > mbex_pkg::ADDR_LIMIT;
    value_bad = 1'b0;
    if (req.func == mbex_pkg::FC_WR_COIL)
    begin
      value_bad = req.value != mbex_pkg::COIL_ON &&
                  req.value != mbex_pkg::COIL_OFF;
    end
    else if (!fc_single(req.func))
    begin
      value_bad = req.qty == 16'h0000;
    end
    exc_code = mbex_pkg::EX_NONE;
    if (gateway_mode && gw_no_path)
    begin
      exc_code = mbex_pkg::EX_GW_PATH;
    end
    else if (gateway_mode && gw_timeout)
    begin
      exc_code = mbex_pkg::EX_GW_TIMEOUT;
    end
    else if (gateway_mode && gw_no_answer)
    begin
      exc_code = mbex_pkg::EX_GW_TARGET;
    end
    else if (dev_fault)
    begin
      exc_code = mbex_pkg::EX_DEV_FAIL;
    end
    else if (dev_busy)
    begin
      // The master is expected to retry later, so nothing is held here.
      exc_code = mbex_pkg::EX_DEV_BUSY;
    end
    else if (func_bad)
    begin
      exc_code = mbex_pkg::EX_ILL_FUNC;
    end
    else if (addr_bad)
    begin
      exc_code = mbex_pkg::EX_ILL_ADDR;
    end
    else if (value_bad)
    begin
      exc_code = mbex_pkg::EX_ILL_VALUE;
    end
  end

  // ----------------------------------------------------------------
  // Reply register
  // ----------------------------------------------------------------
  logic rsp_valid_q;
  logic rsp_valid_d;
  mbex_pkg::mbex_rsp_t rsp_q;
  mbex_pkg::mbex_rsp_t rsp_d;
  mbex_pkg::mbex_type_t type_q;
  mbex_pkg::mbex_type_t type_d;

  // A reply is formed only for intact frames addressed to this unit;
  // anything else is dropped silently.
  always_comb
  begin
    rsp_valid_d = req_valid && frame_ok && unit_match;
    rsp_d = rsp_q;
    type_d = type_q;
    if (rsp_valid_d)
    begin
      rsp_d.unit = req.unit;
      rsp_d.is_exc = exc_code != mbex_pkg::EX_NONE;
      rsp_d.func = (exc_code != mbex_pkg::EX_NONE) ?
                   (req.func | mbex_pkg::FC_ERR_FLAG) : req.func;
      rsp_d.code = exc_code;
      type_d = req_type;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      type_q <= mbex_pkg::MBEX_COIL;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      type_q <= type_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign rsp_type = type_q;

  // ----------------------------------------------------------------
  // Legacy reference decoder
  // ----------------------------------------------------------------
  mbex_pkg::mbex_ref_t ref_d;
  mbex_pkg::mbex_ref_t ref_q;
  logic [19:0] ref_span;
  logic [19:0] ref_digit;
  logic [19:0] ref_numb;
  logic [19:0] ref_limit;

  // Leading digit is the quotient by the span; remainder is the register
  // number, and the address is one less. A division keeps this compact at
  // the cost of area, acceptable for a configuration path.
  always_comb
  begin
    ref_span = ref_six ? mbex_pkg::REF6_SPAN : mbex_pkg::REF5_SPAN;
    ref_limit = ref_six ? mbex_pkg::REF_MAX_NUM
                        : mbex_pkg::REF5_MAX_NUM;
    ref_digit = ref_num / ref_span;
    ref_numb = ref_num % ref_span;
    ref_d = '0;
    ref_d.bit_idx = ref_bit;
    ref_d.addr = 16'(ref_numb - 20'h00001);
    ref_d.valid = ref_numb != 20'h00000 && ref_numb <= ref_limit;
    unique case (ref_digit[3:0])
      mbex_pkg::DIG_COIL: ref_d.rtype = mbex_pkg::MBEX_COIL;
      mbex_pkg::DIG_DISC: ref_d.rtype = mbex_pkg::MBEX_DISC;
      mbex_pkg::DIG_INPT: ref_d.rtype = mbex_pkg::MBEX_INPT;
      mbex_pkg::DIG_HOLD: ref_d.rtype = mbex_pkg::MBEX_HOLD;
      default: ref_d.valid = 1'b0;
    endcase
    if (ref_digit[19:4] != 16'h0000)
    begin
      ref_d.valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wide-value pairing and bit pick
  // ----------------------------------------------------------------
  logic [63:0] wregs_d;
  logic [63:0] wval_d;
  logic [63:0] wregs_q;
  logic [63:0] wval_q;
  logic bit_d;
  logic bit_q;

  // Register k of the group sits in bits [16k+15:16k] of regs. Default
  // order puts the most significant word in register 0; swap reverses.
  always_comb
  begin
    wregs_d = '0;
    wval_d = '0;
    for (int k = 0; k < mbex_pkg::WIDE_REGS; k++)
    begin
      if (k < int'(wide_regs))
      begin
        if (word_swap)
        begin
          wregs_d[k*16 +: 16] = wide_in[k*16 +: 16];
          wval_d[k*16 +: 16] = regs_in[k*16 +: 16];
        end
        else
        begin
          wregs_d[k*16 +: 16] =
            wide_in[(int'(wide_regs) - 1 - k)*16 +: 16];
          wval_d[(int'(wide_regs) - 1 - k)*16 +: 16] =
            regs_in[k*16 +: 16];
        end
      end
    end
    bit_d = bit_word[ref_bit];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ref_q <= '0;
      wregs_q <= '0;
      wval_q <= '0;
      bit_q <= 1'b0;
    end
    else
    begin
      ref_q <= ref_d;
      wregs_q <= wregs_d;
      wval_q <= wval_d;
      bit_q <= bit_d;
    end
  end

  assign ref_out = ref_q;
  assign wide_regs_out = wregs_q;
  assign wide_out = wval_q;
  assign bit_out = bit_q;

endmodule

`default_nettype wire

//--- design/mbex_pkg.sv
/*
  Package for the request checker, exception reply former, legacy reference
  decoder and wide-value register pairing block.
  Assumes a single clock domain; all users refer to names as mbex_pkg::name.
*/
// Function
// - Faulty addressed request gets exception reply
// - Exception reply: address, code with MSB, exception
// - Unknown or barred function gives code 1
// - Missing register anywhere in span gives 2
// - Unacceptable data value gives code 3
// - Internal failure gives 4, busy gives 6
// - Gateway without path gives code 0A
// - Silent downstream target gives code 0B
// - Forwarded request timeout gives code 11
// - Four types, each addressed 0 to 65535
// - Function code selects the register type
// - Leading digit of five-digit reference selects type
// - Address is reference minus range base
// - Six-digit references reach register 65535
// - 32-bit value spans two consecutive registers
// - Wider values span more consecutive registers
// - Default order puts high word first
// - Word swap option reverses register order
// - Bit suffix picks bit, bit 0 LSB
package mbex_pkg;

  // ----------------------------------------------------------------
  // Function codes and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPT = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_HOLD = 8'h06;
  localparam logic [7:0] FC_WM_COIL = 8'h0F;
  localparam logic [7:0] FC_WM_HOLD = 8'h10;
  localparam logic [7:0] FC_ERR_FLAG = 8'h80;

  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_ILL_FUNC = 8'h01;
  localparam logic [7:0] EX_ILL_ADDR = 8'h02;
  localparam logic [7:0] EX_ILL_VALUE = 8'h03;
  localparam logic [7:0] EX_DEV_FAIL = 8'h04;
  localparam logic [7:0] EX_DEV_BUSY = 8'h06;
  localparam logic [7:0] EX_GW_PATH = 8'h0A;
  localparam logic [7:0] EX_GW_TARGET = 8'h0B;
  localparam logic [7:0] EX_GW_TIMEOUT = 8'h11;

  // Single-coil write values that are acceptable.
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [16:0] ADDR_LIMIT = 17'h10000;

  // ----------------------------------------------------------------
  // Legacy reference decoding
  // ----------------------------------------------------------------
  localparam logic [19:0] REF5_SPAN = 20'h02710;   // 10000 per type
  localparam logic [19:0] REF6_SPAN = 20'h186A0;   // 100000 per type
  localparam logic [19:0] REF6_FIRST = 20'h186A1;  // 100001
  localparam logic [19:0] REF_MAX_NUM = 20'h0FFFF; // register number 65535
  localparam logic [19:0] REF5_MAX_NUM = 20'h0270F; // register number 9999
  localparam logic [3:0] DIG_COIL = 4'h0;
  localparam logic [3:0] DIG_DISC = 4'h1;
  localparam logic [3:0] DIG_INPT = 4'h3;
  localparam logic [3:0] DIG_HOLD = 4'h4;

  // ----------------------------------------------------------------
  // Wide-value pairing
  // ----------------------------------------------------------------
  localparam int WIDE_REGS = 4;     // up to 64 bits
  localparam int REG_W = 16;

  typedef enum logic [1:0] {
    MBEX_COIL = 2'b00,
    MBEX_DISC = 2'b01,
    MBEX_INPT = 2'b10,
    MBEX_HOLD = 2'b11
  } mbex_type_t;

  // Parsed request as delivered by the framing logic.
  typedef struct packed {
    logic [7:0] unit;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] value;
  } mbex_req_t;

  // Reply header handed to the transmit side.
  typedef struct packed {
    logic [7:0] unit;
    logic [7:0] func;
    logic [7:0] code;
    logic is_exc;
  } mbex_rsp_t;

  // Per-type register map limits and allowed operations.
  typedef struct packed {
    logic [16:0] size;
    logic rd_ok;
    logic wr_ok;
  } mbex_map_t;

  // Decoded legacy reference.
  typedef struct packed {
    mbex_type_t rtype;
    logic [15:0] addr;
    logic [3:0] bit_idx;
    logic valid;
  } mbex_ref_t;

endpackage

//--- bench/mbex_monitor.sv
/*
  Concurrent checks on the ports of the request checker block.
  Assumes one clock, synchronous active-high reset; bound to mbex_core.
*/
`timescale 1ns/100ps
`default_nettype none
module mbex_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  input var mbex_pkg::mbex_req_t req,
  input wire logic frame_ok,
  input wire logic unit_match,
  // Conditions
  input wire logic gateway_mode,
  input wire logic dev_fault,
  input wire logic dev_busy,
  input wire logic gw_no_path,
  // Reply and bit pick
  input wire logic rsp_valid,
  input var mbex_pkg::mbex_rsp_t rsp,
  input var mbex_pkg::mbex_type_t rsp_type,
  input wire logic [3:0] ref_bit,
  input wire logic [15:0] bit_word,
  input wire logic bit_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A request that reached this unit intact.
  sequence s_taken;
    req_valid && frame_ok && unit_match;
  endsequence
  // The same, on a plain slave with gateway codes off.
  sequence s_local;
    s_taken ##0 !gateway_mode;
  endsequence
  a_reply_given: assert property (s_taken |=> rsp_valid)
    else $error("accepted request got no reply");
  a_no_reply: assert property (req_valid && !(frame_ok && unit_match)
    |=> !rsp_valid) else $error("reply to a refused frame");
  a_stray_pulse: assert property (rsp_valid |-> $past(req_valid))
    else $error("reply without a request");
  a_reply_form: assert property (s_taken |=> rsp.unit == $past(req.unit)
    && rsp.func == ($past(req.func) | (rsp.is_exc ? 8'h80 : 8'h00))
    && rsp.is_exc == (rsp.code != 8'h00))
    else $error("reply header malformed");
  a_fault_code: assert property (s_local ##0 dev_fault
    |=> rsp.code == mbex_pkg::EX_DEV_FAIL)
    else $error("fault code missing");
  a_busy_code: assert property (s_local ##0 !dev_fault && dev_busy
    |=> rsp.code == mbex_pkg::EX_DEV_BUSY)
    else $error("busy code missing");
  a_bad_func: assert property (s_local ##0 !dev_fault && !dev_busy
    && req.func == 8'h07 |=> rsp.code == mbex_pkg::EX_ILL_FUNC)
    else $error("unknown function accepted");
  a_gw_path: assert property (s_taken ##0 gateway_mode && gw_no_path
    |=> rsp.code == mbex_pkg::EX_GW_PATH)
    else $error("path code missing");
  a_hold_type: assert property (s_taken ##0 req.func == 8'h03
    |=> rsp_type == mbex_pkg::MBEX_HOLD)
    else $error("wrong register type");
  // The first edge after reset still sees the cleared register.
  a_bit_pick: assert property (!$past(rst)
    |-> bit_out == $past(bit_word[ref_bit]))
    else $error("wrong bit picked");
endmodule
bind mbex_core mbex_monitor mon (.clk, .rst, .req_valid, .req, .frame_ok,
  .unit_match, .gateway_mode, .dev_fault, .dev_busy, .gw_no_path,
  .rsp_valid, .rsp, .rsp_type, .ref_bit, .bit_word, .bit_out);
`default_nettype wire

//--- bench/mbex_master.sv
/*
  Behavioural master that issues parsed requests and reads the replies.
  Assumes the reply pulse follows the taken edge by one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module mbex_master
(
  // Clock
  input wire logic clk,
  // Request side
  output logic req_valid,
  output var mbex_pkg::mbex_req_t req,
  output logic frame_ok,
  output logic unit_match,
  // Reply side
  input wire logic rsp_valid,
  input var mbex_pkg::mbex_rsp_t rsp
);
  int tries;
  // Idle lines at time zero.
  initial
  begin
    req_valid = 1'b0;
    req = '0;
    frame_ok = 1'b1;
    unit_match = 1'b1;
    tries = 0;
  end
  // One transfer; a busy reply is not final, so it backs off and retries.
  task automatic xfer(input mbex_pkg::mbex_req_t q, input logic fok,
    input logic um, output logic got, output mbex_pkg::mbex_rsp_t r);
    got = 1'b0;
    tries = 0;
    do
    begin
      if (tries > 0)
        repeat (8) @(posedge clk);
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req = q;
      frame_ok = fok;
      unit_match = um;
      tries++;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      req = ~q; // Released fields must not keep the old value.
      got = rsp_valid;
      r = rsp;
    end
    while (got && r.code === mbex_pkg::EX_DEV_BUSY && tries < 4);
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
/*
  Self-checking testbench for the request checker block.
  Assumes the master model and the bound monitor are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid, frame_ok, unit_match, rsp_valid, gateway_mode;
  logic dev_fault, dev_busy, gw_no_path, gw_no_answer, gw_timeout;
  logic ref_six, bit_out, word_swap;
  logic [3:0] ref_bit;
  logic [2:0] wide_regs;
  logic [15:0] bit_word;
  logic [19:0] ref_num;
  logic [63:0] wide_in, wide_regs_out, regs_in, wide_out;
  mbex_pkg::mbex_req_t req;
  mbex_pkg::mbex_rsp_t rsp;
  mbex_pkg::mbex_type_t rsp_type;
  mbex_pkg::mbex_ref_t ref_out;
  mbex_pkg::mbex_map_t [3:0] map_cfg;
  int err_count = 0;
  int n_tests = 0;
  mbex_core dut (.clk, .rst, .req_valid, .req, .frame_ok, .unit_match,
    .map_cfg, .gateway_mode, .dev_fault, .dev_busy, .gw_no_path,
    .gw_no_answer, .gw_timeout, .rsp_valid, .rsp, .rsp_type, .ref_num,
    .ref_six, .ref_bit, .ref_out, .bit_word, .bit_out, .word_swap,
    .wide_regs, .wide_in, .wide_regs_out, .regs_in, .wide_out);
  mbex_master m (.clk, .req_valid, .req, .frame_ok, .unit_match,
    .rsp_valid, .rsp);
  // 25 MHz clock.
  always #20 clk = ~clk;
  // The long command ends once busy has been reported.
  always @(posedge clk)
    if (rsp_valid && rsp.code === mbex_pkg::EX_DEV_BUSY)
      dev_busy <= 1'b0;
  // --------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Flags are {gateway, no path, timeout, no answer, fault, busy}.
  task automatic req_chk(input logic [7:0] fc, input logic [15:0] ad, qt,
    vl, input logic [5:0] fl, input logic [7:0] ex);
    mbex_pkg::mbex_rsp_t r;
    logic got;
    {gateway_mode, gw_no_path, gw_timeout, gw_no_answer, dev_fault,
      dev_busy} = fl;
    m.xfer('{8'h11, fc, ad, qt, vl}, 1'b1, 1'b1, got, r);
    check(got === 1'b1 && r.code === ex && r.unit === 8'h11
      && r.is_exc === (ex != 8'h00) && r.func === (fc | (ex != 8'h00 ?
      mbex_pkg::FC_ERR_FLAG : 8'h00)), "reply code");
    check(rsp_type === ((fc == 8'h01 || fc == 8'h05 || fc == 8'h0F) ?
      mbex_pkg::MBEX_COIL : (fc == 8'h02) ? mbex_pkg::MBEX_DISC :
      (fc == 8'h04) ? mbex_pkg::MBEX_INPT : mbex_pkg::MBEX_HOLD),
      "register type");
  endtask
  task automatic ref_chk(input logic [19:0] n, input logic six,
    input logic [3:0] b, input logic [1:0] t, input logic [15:0] a,
    input logic v);
    ref_num = n;
    ref_six = six;
    ref_bit = b;
    @(posedge clk);
    #1;
    check(ref_out.valid === v && (!v || (ref_out.rtype === t
      && ref_out.addr === a && ref_out.bit_idx === b)), "reference");
    check(bit_out === (b == 4'h0 || b == 4'hF), "bit pick");
  endtask
  task automatic wide_chk(input logic sw, input logic [2:0] n,
    input logic [63:0] v, rg, mk);
    word_swap = sw;
    wide_regs = n;
    wide_in = v;
    regs_in = rg;
    @(posedge clk);
    #1;
    check((wide_regs_out & mk) === rg, "word split");
    check(wide_out === v, "word join");
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_exc;
    req_chk(8'h03, 16'h0000, 16'h0002, 16'h0000, 6'h00, 8'h00);
    req_chk(8'h07, 16'h0000, 16'h0001, 16'h0000, 6'h00, 8'h01);
    req_chk(8'h03, 16'h00FF, 16'h0001, 16'h0000, 6'h00, 8'h00);
    req_chk(8'h03, 16'h00FF, 16'h0002, 16'h0000, 6'h00, 8'h02);
    req_chk(8'h01, 16'hFFFF, 16'h0001, 16'h0000, 6'h00, 8'h00);
    req_chk(8'h01, 16'hFFFF, 16'h0002, 16'h0000, 6'h00, 8'h02);
    req_chk(8'h05, 16'h0003, 16'h0001, 16'h1234, 6'h00, 8'h03);
    req_chk(8'h05, 16'h0003, 16'h0001, 16'hFF00, 6'h00, 8'h00);
    req_chk(8'h10, 16'h0003, 16'h0000, 16'h0000, 6'h00, 8'h03);
    req_chk(8'h03, 16'h0000, 16'h0001, 16'h0000, 6'h02, 8'h04);
    req_chk(8'h03, 16'h0000, 16'h0001, 16'h0000, 6'h10, 8'h00);
    req_chk(8'h03, 16'h0000, 16'h0001, 16'h0000, 6'h30, 8'h0A);
    req_chk(8'h03, 16'h0000, 16'h0001, 16'h0000, 6'h24, 8'h0B);
    req_chk(8'h03, 16'h0000, 16'h0001, 16'h0000, 6'h28, 8'h11);
    req_chk(8'h03, 16'h0000, 16'h0001, 16'h0000, 6'h2C, 8'h11);
    req_chk(8'h04, 16'h0000, 16'h0001, 16'h0000, 6'h01, 8'h00);
    check(m.tries == 2, "busy retry count");
    $display("Test exception codes done");
  endtask
  task automatic t_drop;
    mbex_pkg::mbex_rsp_t r, prev;
    logic got;
    prev = rsp;
    m.xfer('{8'h11, 8'h07, 16'h0, 16'h1, 16'h0}, 1'b0, 1'b1, got, r);
    check(got === 1'b0 && rsp === prev, "bad frame answered");
    m.xfer('{8'h22, 8'h07, 16'h0, 16'h1, 16'h0}, 1'b1, 1'b0, got, r);
    check(got === 1'b0 && rsp === prev, "other unit answered");
    $display("Test silent drop done");
  endtask
  // A reset in mid-run must clear every registered output.
  task automatic t_rst;
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(rsp_valid === 1'b0 && rsp === '0 &&
      rsp_type === mbex_pkg::MBEX_COIL && ref_out === '0 &&
      wide_out === 64'h0 && wide_regs_out === 64'h0 && bit_out === 1'b0,
      "reset state");
    rst = 1'b0;
    $display("Test mid-run reset done");
  endtask
  task automatic t_ref;
    bit_word = 16'h8001;
    ref_chk(20'h00001, 1'b0, 4'h0, 2'h0, 16'h0000, 1'b1);
    ref_chk(20'h0270F, 1'b0, 4'h7, 2'h0, 16'h270E, 1'b1);
    ref_chk(20'h02711, 1'b0, 4'hF, 2'h1, 16'h0000, 1'b1);
    ref_chk(20'h07531, 1'b0, 4'h8, 2'h2, 16'h0000, 1'b1);
    ref_chk(20'h09C41, 1'b0, 4'h7, 2'h3, 16'h0000, 1'b1);
    ref_chk(20'h0C34F, 1'b0, 4'h1, 2'h3, 16'h270E, 1'b1);
    ref_chk(20'h04E21, 1'b0, 4'h0, 2'h0, 16'h0000, 1'b0);
    ref_chk(20'h09C40, 1'b0, 4'h0, 2'h0, 16'h0000, 1'b0);
    ref_chk(20'h71A7F, 1'b1, 4'h7, 2'h3, 16'hFFFE, 1'b1);
    ref_chk(20'h493E1, 1'b1, 4'h0, 2'h2, 16'h0000, 1'b1);
    ref_chk(20'h2869F, 1'b1, 4'hF, 2'h1, 16'hFFFE, 1'b1);
    $display("Test reference decode done");
  endtask
  task automatic t_wide;
    wide_chk(1'b0, 3'h2, 64'h12345678, 64'h56781234, 64'hFFFFFFFF);
    wide_chk(1'b1, 3'h2, 64'h12345678, 64'h12345678, 64'hFFFFFFFF);
    wide_chk(1'b0, 3'h4, 64'h0123456789ABCDEF, 64'hCDEF89AB45670123,
      64'hFFFFFFFFFFFFFFFF);
    wide_chk(1'b1, 3'h4, 64'h0123456789ABCDEF, 64'h0123456789ABCDEF,
      64'hFFFFFFFFFFFFFFFF);
    $display("Test wide values done");
  endtask
  // Cut a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
  // Main sequence.
  initial
  begin
    {gateway_mode, gw_no_path, gw_timeout, gw_no_answer} = 4'h0;
    {dev_fault, dev_busy, ref_six, word_swap} = 4'h0;
    ref_num = 20'h00001;
    ref_bit = 4'h0;
    bit_word = 16'h0000;
    wide_regs = 3'h2;
    wide_in = 64'h0;
    regs_in = 64'h0;
    map_cfg[0] = '{17'h10000, 1'b1, 1'b1};
    map_cfg[1] = '{17'h10000, 1'b1, 1'b0};
    map_cfg[2] = '{17'h00100, 1'b1, 1'b0};
    map_cfg[3] = '{17'h00100, 1'b1, 1'b1};
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_exc;
    t_drop;
    t_rst;
    t_ref;
    t_wide;
    stop_test;
  end
endmodule
`default_nettype wire
